// File: inc/gie_pkg.sv
// Constants for the graphics instruction executor
//==================================================================
`default_nettype none
package gie_pkg;
  localparam int DW = 16;
  localparam int CW = 14;
  localparam int COLW = 10;
  localparam int REG_AW = 3;
  //================================================================
  // Opcodes
  localparam logic [15:0] OPC_INQUIRE = 16'h003F;
  localparam logic [7:0] OPC_JUMP_LO = 8'h3C;
  localparam logic [3:0] OPC_JUMP_MID = 4'h0;
  localparam logic [7:0] OPC_LINE_LO = 8'h4C;
  //================================================================
  // Opcode and operand fields
  localparam int F_AA = 15;
  localparam int F_SI = 14;
  localparam int F_M = 13;
  localparam int F_LS = 12;
  localparam int F_EP = 11;
  localparam int F_OP = 8;
  localparam int F_PP = 14;
  localparam int F_TBL = 13;
  localparam int F_SGN = 12;
  localparam int F_AM = 15;
  localparam int F_CONT = 15;
  localparam int SIGN_BIT = 13;
  localparam logic [2:0] CMB_SET = 3'h5;
  localparam logic [2:0] CMB_XOR = 3'h7;
  //================================================================
  // Timing in core clock cycles
  localparam logic [8:0] INQ_CYC = 9'h03C;
  localparam logic [8:0] JMP_CYC = 9'h060;
  localparam logic [8:0] INQ_CNT = INQ_CYC - 9'h001;
  localparam logic [8:0] JMP_CNT = JMP_CYC - 9'h001;
  localparam logic [8:0] PIX_SET = 9'h006;
  localparam logic [8:0] PIX_XOR = 9'h00C;
  localparam logic [8:0] PIX_DASH = 9'h00E;
  localparam logic [8:0] PIX_AA = 9'h05F;
  localparam logic [8:0] PIX_PAT1 = 9'h0C8;
  localparam logic [8:0] PIX_PAT2 = 9'h0F0;
  localparam logic [8:0] PIX_PAT4 = 9'h149;
  localparam logic [8:0] PIX_OFS = 9'h002;
  //================================================================
  // Registers
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_PENX = 3'h2;
  localparam logic [2:0] REG_PENY = 3'h3;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam int CTL_BRUSH = 0;
  localparam int CTL_PSZ = 1;
  localparam int CTL_SCOL = 4;
endpackage : gie_pkg
`default_nettype wire

// File: core/gie_executor.sv
// Instruction executor: inquiry, jump and vector drawing
`default_nettype none
module gie_executor #(
  parameter logic [15:0] VERSION_WORD = 16'h5A01 // Arbitrary value
) (
  input wire logic i_mclk, // Core clock
  input wire logic i_rstn, // Async reset
  input wire logic [gie_pkg::DW-1:0] i_word, // Instruction word
  input wire logic i_word_valid, // Word offered
  output logic o_word_ready, // Word taken
  output logic o_instr_done, // Instruction end
  input wire logic i_obq_full, // Outbound queue full
  output logic o_obq_push, // Outbound write
  output logic [gie_pkg::DW-1:0] o_obq_data, // Outbound word
  output logic o_mem_rd, // Memory read
  output logic o_mem_wr, // Memory write
  output logic [gie_pkg::COLW-1:0] o_mem_col, // Word column
  output logic [gie_pkg::CW-1:0] o_mem_row, // Scan line
  output logic [1:0] o_mem_plane, // Read plane
  output logic [gie_pkg::DW-1:0] o_mem_wdata, // Pixel data
  output logic [gie_pkg::DW-1:0] o_mem_wmask, // Pixel mask
  output logic [2:0] o_combine_op, // Merge mode
  input wire logic [gie_pkg::DW-1:0] i_mem_rdata, // Read data
  output logic o_smooth, // Anti-aliasing on
  output logic o_pat_src, // Pattern source
  input wire logic i_brush_bit, // Pattern bit
  input wire logic i_dash_on, // Inside dash or dot
  output logic o_tex_step, // Texture advance
  output logic o_jump_taken, // Fetch redirect
  output logic [1:0] o_fetch_plane, // Fetch plane
  output logic [gie_pkg::CW-1:0] o_fetch_x, // Fetch X
  output logic [gie_pkg::CW-1:0] o_fetch_y, // Fetch Y
  output logic [gie_pkg::CW-1:0] o_pen_x, // Pen X
  output logic [gie_pkg::CW-1:0] o_pen_y, // Pen Y
  input wire logic [gie_pkg::REG_AW-1:0] i_reg_addr, // Reg address
  input wire logic [gie_pkg::DW-1:0] i_reg_wdata, // Reg write data
  input wire logic i_reg_wr, // Reg write
  input wire logic i_reg_rd, // Reg read
  output logic [gie_pkg::DW-1:0] o_reg_rdata // Reg read data
);
  import gie_pkg::*;

  //================================================================
  // State
  typedef enum logic [3:0] {
    S_IDLE,
    S_INQ,
    S_JOPS,
    S_JRD0,
    S_JRD1,
    S_JRD2,
    S_JRD3,
    S_JWAIT,
    S_VOPS,
    S_PIX,
    S_PRD1,
    S_PRD2,
    S_PIXW
  } gie_st_t;

  typedef struct packed {
    gie_st_t st;
    logic [15:0] opc;
    logic [1:0] wc;
    logic [8:0] cnt;
    logic [13:0] pen_x;
    logic [13:0] pen_y;
    logic [13:0] bx;
    logic [13:0] by;
    logic [13:0] x;
    logic [13:0] y;
    logic [13:0] ex;
    logic [13:0] ey;
    logic [15:0] err;
    logic [15:0] dx;
    logic [15:0] dy;
    logic sxn;
    logic syn;
    logic span;
    logic first;
    logic last;
    logic cont;
    logic am;
    logic pushed;
    logic push;
    logic done;
    logic jtake;
    logic tex;
    logic rd;
    logic wr;
    logic smooth;
    logic psrc;
    logic [9:0] col;
    logic [13:0] row;
    logic [15:0] wdata;
    logic [15:0] wmask;
    logic [1:0] fplane;
    logic [13:0] fx;
    logic [13:0] fy;
    logic [15:0] ctrl;
    logic [15:0] rdata;
  } gie_state_t;

  gie_state_t r_reg;
  gie_state_t r_next;

  logic [13:0] dw;
  logic [13:0] ny;
  logic [15:0] ddx;
  logic [15:0] ddy;
  logic [15:0] adx;
  logic [15:0] ady;
  logic [15:0] e2;
  logic [15:0] pmask;
  logic [8:0] cost;
  logic [1:0] psz;
  logic [3:0] scol;
  logic brush;
  logic lastp;
  logic draw;
  logic c1;
  logic c2;
  logic sp;

  assign brush = r_reg.ctrl[CTL_BRUSH];
  assign psz = r_reg.ctrl[CTL_PSZ+:2];
  assign scol = r_reg.ctrl[CTL_SCOL+:4];
  assign dw = i_word[13:0];

  //================================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    ny = 14'h0000;
    ddx = 16'h0000;
    ddy = 16'h0000;
    adx = 16'h0000;
    ady = 16'h0000;
    e2 = 16'h0000;
    pmask = 16'h0000;
    lastp = 1'b0;
    draw = 1'b0;
    c1 = 1'b0;
    c2 = 1'b0;
    sp = 1'b0;
    r_next.rd = 1'b0;
    r_next.wr = 1'b0;
    r_next.push = 1'b0;
    r_next.done = 1'b0;
    r_next.jtake = 1'b0;
    r_next.tex = 1'b0;
    if (r_reg.cnt != 9'h000) begin
      r_next.cnt = r_reg.cnt - 9'h001;
    end
    // Pixel cost by style
    if (brush) begin
      case (psz)
        2'h0: cost = PIX_PAT1;
        2'h1: cost = PIX_PAT2;
        default: cost = PIX_PAT4;
      endcase
    end else if (r_reg.opc[F_AA]) begin
      cost = PIX_AA;
    end else if (r_reg.opc[F_LS]) begin
      cost = PIX_DASH;
    end else if (r_reg.opc[F_OP+:3] == CMB_SET) begin
      cost = PIX_SET;
    end else begin
      cost = PIX_XOR;
    end
    // Register port
    if (i_reg_wr && i_reg_addr == REG_CTRL) begin
      r_next.ctrl = i_reg_wdata;
    end
    r_next.rdata = 16'h0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        REG_CTRL: r_next.rdata = r_reg.ctrl;
        REG_STAT: r_next.rdata = {13'h0000, r_reg.st != S_IDLE,
                                  r_reg.fplane};
        REG_PENX: r_next.rdata = {2'h0, r_reg.pen_x};
        REG_PENY: r_next.rdata = {2'h0, r_reg.pen_y};
        default: r_next.rdata = 16'h0000;
      endcase
    end
    case (r_reg.st)
      S_IDLE: begin
        if (i_word_valid) begin
          r_next.opc = i_word;
          r_next.wc = 2'h0;
          if (i_word == OPC_INQUIRE) begin
            r_next.st = S_INQ;
            r_next.cnt = INQ_CNT;
            r_next.pushed = 1'b0;
          end else if (i_word[7:0] == OPC_JUMP_LO &&
                       i_word[11:8] == OPC_JUMP_MID) begin
            r_next.st = S_JOPS;
            r_next.cnt = JMP_CNT;
          end else if (i_word[7:0] == OPC_LINE_LO) begin
            r_next.st = S_VOPS;
            r_next.bx = r_reg.pen_x;
            r_next.by = r_reg.pen_y;
          end else begin
            r_next.done = 1'b1;
          end
        end
      end
      S_INQ: begin
        if (!r_reg.pushed) begin
          if (!i_obq_full) begin
            r_next.push = 1'b1;
            r_next.pushed = 1'b1;
          end else begin
            r_next.cnt = r_reg.cnt;
          end
        end else if (r_reg.cnt == 9'h000) begin
          r_next.done = 1'b1;
          r_next.st = S_IDLE;
        end
      end
      S_JOPS: begin
        if (i_word_valid) begin
          r_next.wc = r_reg.wc + 2'h1;
          case (r_reg.wc)
            2'h0: begin
              r_next.am = i_word[F_AM];
              r_next.ex = i_word[F_AM] ? r_reg.pen_x + dw : dw;
            end
            2'h1: begin
              r_next.ey = r_reg.am ? r_reg.pen_y + dw : dw;
              if (!r_reg.opc[F_TBL]) begin
                r_next.st = S_JWAIT;
              end
            end
            default: begin
              r_next.col = r_reg.ex[13:4] + {i_word[8:0], 1'b0};
              r_next.st = S_JRD0;
            end
          endcase
        end
      end
      S_JRD0: begin
        r_next.rd = 1'b1;
        r_next.row = r_reg.ey;
        r_next.st = S_JRD1;
      end
      S_JRD1: begin
        r_next.rd = 1'b1;
        r_next.col = r_reg.col + 10'h001;
        r_next.st = S_JRD2;
      end
      S_JRD2: begin
        r_next.ex = i_mem_rdata[13:0];
        r_next.st = S_JRD3;
      end
      S_JRD3: begin
        r_next.ey = i_mem_rdata[13:0];
        r_next.st = S_JWAIT;
      end
      S_JWAIT: begin
        if (r_reg.cnt == 9'h000) begin
          r_next.done = 1'b1;
          r_next.st = S_IDLE;
          if (r_reg.opc[F_TBL] || !r_reg.opc[F_SGN] ||
              !r_reg.pen_y[SIGN_BIT]) begin
            r_next.jtake = 1'b1;
            r_next.fplane = r_reg.opc[F_PP+:2];
            r_next.fx = r_reg.ex;
            r_next.fy = r_reg.ey;
          end
        end
      end
      S_VOPS: begin
        if (i_word_valid) begin
          r_next.wc = r_reg.wc + 2'h1;
          case (r_reg.wc)
            2'h0: begin
              r_next.am = i_word[F_AM];
              r_next.x = i_word[F_AM] ? r_reg.bx + dw : dw;
            end
            2'h1: begin
              r_next.y = r_reg.am ? r_reg.by + dw : dw;
            end
            2'h2: begin
              r_next.am = i_word[F_AM];
              r_next.ex = i_word[F_AM] ? r_reg.x + dw : dw;
            end
            default: begin
              ny = r_reg.am ? r_reg.y + dw : dw;
              r_next.ey = ny;
              r_next.cont = i_word[F_CONT];
              ddx = {2'h0, r_reg.ex} - {2'h0, r_reg.x};
              ddy = {2'h0, ny} - {2'h0, r_reg.y};
              adx = ddx[15] ? 16'h0000 - ddx : ddx;
              ady = ddy[15] ? 16'h0000 - ddy : ddy;
              r_next.sxn = ddx[15];
              r_next.syn = ddy[15];
              r_next.dx = adx;
              r_next.dy = 16'h0000 - ady;
              r_next.err = adx - ady;
              sp = ady == 16'h0000 && !r_reg.opc[F_LS] &&
                   !r_reg.opc[F_AA] && !brush;
              r_next.span = sp;
              if (sp && ddx[15]) begin
                r_next.x = r_reg.ex;
                r_next.ex = r_reg.x;
                r_next.sxn = 1'b0;
              end
              r_next.smooth = r_reg.opc[F_AA] && !brush;
              r_next.psrc = r_reg.opc[F_AA] && brush;
              r_next.first = 1'b1;
              r_next.st = S_PIX;
            end
          endcase
        end
      end
      S_PIX: begin
        if (r_reg.span) begin
          lastp = r_reg.x[13:4] == r_reg.ex[13:4];
          for (int p = 0; p < 16; p++) begin
            if (4'(p) >= r_reg.x[3:0] &&
                (!lastp || 4'(p) <= r_reg.ex[3:0])) begin
              pmask[15-p] = 1'b1;
            end
          end
        end else begin
          lastp = r_reg.x == r_reg.ex && r_reg.y == r_reg.ey;
          pmask = 16'h8000 >> r_reg.x[3:0];
        end
        draw = r_reg.first || !r_reg.opc[F_LS] || i_dash_on ||
               (lastp && !r_reg.opc[F_EP]);
        r_next.last = lastp;
        r_next.tex = 1'b1;
        r_next.col = r_reg.x[13:4];
        r_next.row = r_reg.y;
        r_next.wmask = draw ? pmask : 16'h0000;
        r_next.wdata = brush ? {16{i_brush_bit ^ r_reg.opc[F_SI]}}
                             : 16'hFFFF;
        r_next.cnt = cost - PIX_OFS;
        if (brush && r_reg.opc[F_M]) begin
          r_next.rd = 1'b1;
          r_next.st = S_PRD1;
        end else begin
          r_next.wr = draw;
          r_next.st = S_PIXW;
        end
      end
      S_PRD1: begin
        r_next.st = S_PRD2;
      end
      S_PRD2: begin
        r_next.wr = i_mem_rdata[3:0] == scol &&
                    r_reg.wmask != 16'h0000;
        r_next.st = S_PIXW;
      end
      S_PIXW: begin
        if (r_reg.cnt == 9'h000) begin
          r_next.first = 1'b0;
          if (r_reg.last && r_reg.cont) begin
            r_next.bx = r_reg.ex;
            r_next.by = r_reg.ey;
            r_next.wc = 2'h0;
            r_next.st = S_VOPS;
          end else if (r_reg.last) begin
            r_next.pen_x = r_reg.ex;
            r_next.pen_y = r_reg.ey;
            r_next.done = 1'b1;
            r_next.st = S_IDLE;
          end else if (r_reg.span) begin
            r_next.x = {r_reg.x[13:4] + 10'h001, 4'h0};
            r_next.st = S_PIX;
          end else begin
            e2 = {r_reg.err[14:0], 1'b0};
            c1 = $signed(e2) >= $signed(r_reg.dy);
            c2 = $signed(e2) <= $signed(r_reg.dx);
            r_next.err = r_reg.err + (c1 ? r_reg.dy : 16'h0000) +
                         (c2 ? r_reg.dx : 16'h0000);
            if (c1) begin
              r_next.x = r_reg.x + (r_reg.sxn ? 14'h3FFF : 14'h0001);
            end
            if (c2) begin
              r_next.y = r_reg.y + (r_reg.syn ? 14'h3FFF : 14'h0001);
            end
            r_next.st = S_PIX;
          end
        end
      end
      default: begin
        r_next.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  //================================================================
  // Outputs
  assign o_word_ready = r_reg.st == S_IDLE || r_reg.st == S_JOPS ||
                        r_reg.st == S_VOPS;
  assign o_instr_done = r_reg.done;
  assign o_obq_push = r_reg.push;
  assign o_obq_data = VERSION_WORD;
  assign o_mem_rd = r_reg.rd;
  assign o_mem_wr = r_reg.wr;
  assign o_mem_col = r_reg.col;
  assign o_mem_row = r_reg.row;
  assign o_mem_plane = 2'h0;
  assign o_mem_wdata = r_reg.wdata;
  assign o_mem_wmask = r_reg.wmask;
  assign o_combine_op = r_reg.opc[F_OP+:3];
  assign o_smooth = r_reg.smooth;
  assign o_pat_src = r_reg.psrc;
  assign o_tex_step = r_reg.tex;
  assign o_jump_taken = r_reg.jtake;
  assign o_fetch_plane = r_reg.fplane;
  assign o_fetch_x = r_reg.fx;
  assign o_fetch_y = r_reg.fy;
  assign o_pen_x = r_reg.pen_x;
  assign o_pen_y = r_reg.pen_y;
  assign o_reg_rdata = r_reg.rdata;

  //================================================================
  // Checks
  logic [9:0] icyc;
  logic [9:0] waits;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      icyc <= 10'h000;
      waits <= 10'h000;
    end else if (i_word_valid && r_reg.st == S_IDLE) begin
      icyc <= 10'h000;
      waits <= 10'h000;
    end else begin
      if (icyc != 10'h3FF) begin
        icyc <= icyc + 10'h001;
      end
      if (r_reg.st == S_INQ && !r_reg.pushed && i_obq_full) begin
        waits <= waits + 10'h001;
      end
    end
  end

  property p_inq_word; @(posedge i_mclk) disable iff (!i_rstn)
    o_obq_push |-> o_obq_data == VERSION_WORD; endproperty
  a_inq_word: assert property (p_inq_word) else $error("bad word");
  property p_inq_room; @(posedge i_mclk) disable iff (!i_rstn)
    o_obq_push |-> !$past(i_obq_full); endproperty
  a_inq_room: assert property (p_inq_room) else $error("push full");
  property p_inq_time; @(posedge i_mclk) disable iff (!i_rstn)
    o_instr_done && r_reg.opc == OPC_INQUIRE
      |-> icyc == {1'b0, INQ_CYC} + waits; endproperty
  a_inq_time: assert property (p_inq_time) else $error("inq time");
  property p_jmp_time; @(posedge i_mclk) disable iff (!i_rstn)
    o_jump_taken |-> icyc >= {1'b0, JMP_CYC}; endproperty
  a_jmp_time: assert property (p_jmp_time) else $error("jmp time");
  property p_jmp_pen; @(posedge i_mclk) disable iff (!i_rstn)
    r_reg.st == S_JWAIT |=> $stable(o_pen_x) && $stable(o_pen_y);
  endproperty
  a_jmp_pen: assert property (p_jmp_pen) else $error("pen moved");
  property p_jmp_cond; @(posedge i_mclk) disable iff (!i_rstn)
    o_jump_taken |-> r_reg.opc[F_TBL] || !r_reg.opc[F_SGN] ||
      !o_pen_y[SIGN_BIT]; endproperty
  a_jmp_cond: assert property (p_jmp_cond) else $error("bad jump");
  property p_jmp_plane; @(posedge i_mclk) disable iff (!i_rstn)
    o_jump_taken |-> o_fetch_plane == r_reg.opc[F_PP+:2]; endproperty
  a_jmp_plane: assert property (p_jmp_plane) else $error("plane");
  property p_vec_pen; @(posedge i_mclk) disable iff (!i_rstn)
    $changed(o_pen_x) || $changed(o_pen_y) |-> o_instr_done &&
      o_pen_x == r_reg.ex && o_pen_y == r_reg.ey; endproperty
  a_vec_pen: assert property (p_vec_pen) else $error("pen end");
  property p_no_fetch; @(posedge i_mclk) disable iff (!i_rstn)
    r_reg.st == S_PIXW |-> !o_word_ready; endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("early");
  property p_search; @(posedge i_mclk) disable iff (!i_rstn)
    o_mem_wr && $past(r_reg.st) == S_PRD2
      |-> $past(i_mem_rdata[3:0]) == scol; endproperty
  a_search: assert property (p_search) else $error("search");

endmodule : gie_executor
`default_nettype wire

// File: verif/gie_host_model.sv
// Host queue drain and display memory model facing the executor
`default_nettype none
module gie_host_model (
  input wire logic i_mclk, // Core clock
  input wire logic i_rstn, // Async reset
  input wire logic i_hold, // Host stops draining
  input wire logic i_obq_push, // Outbound write
  output logic o_obq_full, // Queue full
  input wire logic i_mem_rd, // Memory read
  input wire logic [9:0] i_mem_col, // Word column
  output logic [15:0] o_mem_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic occ_reg;
  assign o_obq_full = occ_reg | i_hold;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      occ_reg <= 1'b0;
      o_mem_rdata <= 16'h0000;
    end else begin
      occ_reg <= i_obq_push | (occ_reg & i_hold);
      // Word holds its own column; idle bus flips every cycle
      o_mem_rdata <= i_mem_rd ? {6'h00, i_mem_col} : ~o_mem_rdata;
    end
  end
endmodule : gie_host_model
`default_nettype wire

// File: verif/gie_executor_tb_top.sv
// Self-checking bench for the graphics instruction executor
`default_nettype none
module gie_executor_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gie_pkg::*;
  localparam logic [15:0] VER = 16'hC3A5; // Arbitrary value
  localparam logic [15:0] V_OPC [10] = '{16'h454C, 16'h074C, 16'h154C,
    16'h854C, 16'h454C, 16'h054C, 16'h854C, 16'h1D4C, 16'h254C, 16'h254C};
  localparam int V_CTL [10] = '{0, 0, 0, 0, 1, 3, 5, 0, 17, 33};
  localparam int V_CYC [10] = '{6, 12, 14, 95, 200, 240, 329, 14, 200, 0};
  localparam int V_NW [10] = '{2, 2, 2, 2, 2, 2, 2, 1, 2, 0};
  logic i_mclk, i_rstn, i_word_valid, o_word_ready, o_instr_done, hold;
  logic i_obq_full, o_obq_push, o_mem_rd, o_mem_wr, o_smooth, o_pat_src;
  logic i_brush_bit, i_dash_on, o_tex_step, o_jump_taken, i_reg_wr, i_reg_rd;
  logic [15:0] i_word, o_obq_data, o_mem_wdata, o_mem_wmask, i_mem_rdata;
  logic [15:0] i_reg_wdata, o_reg_rdata;
  logic [9:0] o_mem_col;
  logic [13:0] o_mem_row, o_fetch_x, o_fetch_y, o_pen_x, o_pen_y;
  logic [1:0] o_mem_plane, o_fetch_plane;
  logic [2:0] o_combine_op, i_reg_addr;
  int num_errors = 0, n_compared = 0, cyc = 0, pushes = 0, steps = 0;
  int wr_t[$];
  logic [2:0] wr_o[$];
  logic [15:0] wr_d[$];
  logic [29:0] wr_m[$];
  gie_executor #(.VERSION_WORD(VER)) uut (.i_mclk, .i_rstn, .i_word,
    .i_word_valid, .o_word_ready, .o_instr_done, .i_obq_full, .o_obq_push,
    .o_obq_data, .o_mem_rd, .o_mem_wr, .o_mem_col, .o_mem_row, .o_mem_plane,
    .o_mem_wdata, .o_mem_wmask, .o_combine_op, .i_mem_rdata, .o_smooth,
    .o_pat_src, .i_brush_bit, .i_dash_on, .o_tex_step, .o_jump_taken,
    .o_fetch_plane, .o_fetch_x, .o_fetch_y, .o_pen_x, .o_pen_y, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);
  gie_host_model host (.i_mclk, .i_rstn, .i_hold(hold),
    .i_obq_push(o_obq_push), .o_obq_full(i_obq_full), .i_mem_rd(o_mem_rd),
    .i_mem_col(o_mem_col), .o_mem_rdata(i_mem_rdata));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) cyc <= cyc + 1;
  //================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  always @(negedge i_mclk) begin
    if (o_mem_wr) begin
      wr_t.push_back(cyc);
      wr_o.push_back(o_combine_op);
      wr_d.push_back(o_mem_wdata);
      wr_m.push_back({o_mem_row, o_mem_wmask});
    end
    if (o_mem_rd) chk("read plane", 0, o_mem_plane);
    if (o_obq_push) pushes++;
    if (o_tex_step) steps++;
  end
  task automatic prog(input logic [15:0] w[$], output int t0);
    int k;
    t0 = -1;
    @(posedge i_mclk);
    foreach (w[i]) begin
      i_word <= w[i];
      i_word_valid <= 1'b1;
      k = 0;
      @(negedge i_mclk);
      while (!o_word_ready && k < 3000) begin
        @(negedge i_mclk);
        k++;
      end
      chk("word ready", 1, o_word_ready);
      if (t0 < 0) t0 = cyc + 1;
      @(posedge i_mclk);
    end
    i_word_valid <= 1'b0;
  endtask : prog
  task automatic wait_done(output int t);
    int k;
    k = 0;
    @(negedge i_mclk);
    while (o_instr_done !== 1'b1 && k < 3000) begin
      @(negedge i_mclk);
      k++;
    end
    chk("instruction done", 1, o_instr_done);
    t = cyc;
  endtask : wait_done
  task automatic rw(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask : rw
  task automatic rchk(input string nm, logic [2:0] a, logic [15:0] e);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    @(negedge i_mclk);
    chk(nm, e, o_reg_rdata);
  endtask : rchk
  //================================================================
  // Scenarios
  task automatic t_regs();
    rchk("ctrl reset", REG_CTRL, CTRL_RST);
    rw(REG_CTRL, 16'hA5F1);
    rchk("ctrl", REG_CTRL, 16'hA5F1);
    rw(REG_PENX, 16'h1234);
    rchk("pen x ro", REG_PENX, 16'h0000);
    rchk("unmapped", 3'h5, 16'h0000);
    rw(REG_CTRL, 16'h0000);
  endtask : t_regs
  task automatic t_inquiry();
    int t0, t1, p;
    p = pushes;
    prog('{OPC_INQUIRE}, t0);
    wait_done(t1);
    chk("inquiry cycles", 60, t1 - t0);
    chk("pushes", p + 1, pushes);
    chk("version", VER, o_obq_data);
    @(posedge i_mclk);
    hold <= 1'b1;
    prog('{OPC_INQUIRE}, t0);
    repeat (10) @(posedge i_mclk);
    hold <= 1'b0;
    chk("push while full", p + 1, pushes);
    wait_done(t1);
    chk("stalled cycles", 70, t1 - t0);
    chk("stalled pushes", p + 2, pushes);
  endtask : t_inquiry
  task automatic t_chain();
    int t0, t1;
    wr_t.delete();
    wr_o.delete();
    prog('{16'h054C, 16'h0010, 16'h0001, 16'h8000, 16'h8001, 16'h8000,
      16'h0000, 16'h8000, 16'h0001}, t0);
    wait_done(t1);
    chk("chain writes", 4, wr_t.size());
    chk("chain op", 5, wr_o[3]);
    chk("writes before done", 1, wr_t[3] <= t1);
    rchk("pen y", REG_PENY, 16'h0003);
    wr_t.delete();
    prog('{16'h054C, 16'h0000, 16'h0040, 16'h001F, 16'h0040}, t0);
    wait_done(t1);
    chk("span writes", 2, wr_t.size());
  endtask : t_chain
  task automatic t_costs();
    int t0, t1, s;
    for (int i = 0; i < 10; i++) begin
      rw(REG_CTRL, V_CTL[i][15:0]);
      wr_t.delete();
      wr_o.delete();
      wr_d.delete();
      wr_m.delete();
      s = steps;
      prog('{V_OPC[i], 16'h0010, 16'h1FFF, 16'h0010, 16'h2000}, t0);
      wait_done(t1);
      chk("writes", V_NW[i], wr_t.size());
      chk("texture steps", 2, steps - s);
      if (V_NW[i] == 2) begin
        chk("row and mask", {14'h1FFF, 16'h8000}, wr_m[0]);
        chk("pixel cycles", V_CYC[i], wr_t[1] - wr_t[0]);
        chk("combine op", V_OPC[i][10:8], wr_o[1]);
        chk("wdata", V_CTL[i][0] ? {16{~V_OPC[i][14]}} : 16'hFFFF,
          wr_d[0]);
      end
      chk("smooth", V_OPC[i][15] & ~V_CTL[i][0], o_smooth);
      chk("pattern src", V_OPC[i][15] & V_CTL[i][0], o_pat_src);
      chk("pen y", 14'h2000, o_pen_y);
    end
    rw(REG_CTRL, 16'h0000);
  endtask : t_costs
  task automatic t_jmp(input logic [15:0] opc, x, y, ix, input logic tk,
    input logic [1:0] pl, input logic [13:0] fx, fy);
    int t0, t1;
    if (opc[13]) prog('{opc, x, y, ix}, t0);
    else prog('{opc, x, y}, t0);
    wait_done(t1);
    chk("jump cycles", 96, t1 - t0);
    chk("jump taken", tk, o_jump_taken);
    chk("fetch plane", pl, o_fetch_plane);
    chk("fetch x", fx, o_fetch_x);
    chk("fetch y", fy, o_fetch_y);
    chk("pen kept", {14'h0010, 14'h2000}, {o_pen_x, o_pen_y});
  endtask : t_jmp
  //================================================================
  // Main sequence
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial begin
    i_rstn = 1'b0;
    i_word = 16'h0000;
    i_word_valid = 1'b0;
    hold = 1'b0;
    i_brush_bit = 1'b1;
    i_dash_on = 1'b0;
    i_reg_addr = 3'h0;
    i_reg_wdata = 16'h0000;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    repeat (20) @(posedge i_mclk);
    i_rstn <= 1'b1;
    t_regs();
    t_inquiry();
    t_chain();
    t_costs();
    // Aligned targets, table index upper bits clear
    t_jmp(16'hC03C, 16'h0200, 16'h0100, '0, 1, 3, 14'h200, 14'h100);
    t_jmp(16'h503C, 16'h0400, 16'h0100, '0, 0, 3, 14'h200, 14'h100);
    t_jmp(16'hB03C, 16'h0100, 16'h0005, 16'h3, 1, 2, 14'h16, 14'h17);
    rchk("status", REG_STAT, 16'h0002);
    end_sim();
  end
endmodule : gie_executor_tb_top
`default_nettype wire
